// ==== logic/fault_prot_defs.svh ====
// fault protection constants: register offsets, field positions, reset values, timing
// assumes a 100 MHz core clock; all times rounded to whole clock cycles
`ifndef FAULT_PROT_DEFS_SVH
`define FAULT_PROT_DEFS_SVH

`define CLK_MHZ 100
// register byte offsets
`define ADDR_CTRL 8'h00
`define ADDR_FCFG 8'h04
`define ADDR_STATUS 8'h08
`define ADDR_IRQ_ST 8'h0c
`define ADDR_IRQ_MASK 8'h10
// control word fields
`define CTRL_EN_BIT 0
`define CTRL_OTSEL_LO 1
`define CTRL_OTSEL_HI 2
`define CTRL_LSDIS_BIT 4
`define CTRL_HSDIS_BIT 5
// fault config word fields
`define FCFG_LS_LO 0
`define FCFG_LS_HI 3
`define FCFG_HS_LO 8
`define FCFG_HS_HI 11
`define FCFG_FILT_LO 16
`define FCFG_FILT_HI 17
`define FCFG_DELAY_BIT 18
// reset values
`define LS_LEVEL_RST 4'h6
`define HS_LEVEL_MIN 4'h2
`define FILT_RST 2'h1
`define IRQ_BITS 6
// spike filter times (ns) and cycle counts, least times rounded up
`define FILT0_NS 100
`define FILT1_NS 1000
`define FILT2_NS 2000
`define FILT3_NS 3000
`define FILT0_CYC ((`FILT0_NS * `CLK_MHZ + 999) / 1000)
`define FILT1_CYC ((`FILT1_NS * `CLK_MHZ + 999) / 1000)
`define FILT2_CYC ((`FILT2_NS * `CLK_MHZ + 999) / 1000)
`define FILT3_CYC ((`FILT3_NS * `CLK_MHZ + 999) / 1000)
// detection blanking after bridge switching
`define BLANK0_NS 750
`define BLANK1_NS 1500
`define BLANK0_CYC ((`BLANK0_NS * `CLK_MHZ + 999) / 1000)
`define BLANK1_CYC ((`BLANK1_NS * `CLK_MHZ + 999) / 1000)
// retry timing: bridge off time per retry, clean run time that forgets retries
`define RETRY_OFF_NS 2000
`define RETRY_HOLD_NS 40000
`define RETRY_OFF_CYC ((`RETRY_OFF_NS * `CLK_MHZ + 999) / 1000)
`define RETRY_HOLD_CYC ((`RETRY_HOLD_NS * `CLK_MHZ + 999) / 1000)
`define RETRY_MAX 2'h3

`endif

// ==== logic/fault_prot_pkg.sv ====
// types shared by the fault protection block
// constants live in fault_prot_defs.svh
package fault_prot_pkg;
  // per-bridge short handling; gray codes along run -> retry -> latched
  typedef enum logic [1:0] {
    BR_RUN = 2'b00,
    BR_RETRY = 2'b01,
    BR_LATCH = 2'b11
  } bridge_state_t;

  // fault detector configuration as held in its register
  typedef struct packed {
    logic blank_long;
    logic [1:0] filt_sel;
    logic [3:0] hs_level;
    logic [3:0] ls_level;
  } fault_cfg_t;

  // driver control word
  typedef struct packed {
    logic hs_dis;
    logic ls_dis;
    logic [1:0] ot_sel;
    logic drv_en;
  } ctrl_t;
endpackage : fault_prot_pkg

// ==== logic/spike_filter.sv ====
// spike filter for one synchronised short detector line
// input must already be in the core clock domain
`timescale 1ns/100ps
`include "fault_prot_defs.svh"
`default_nettype none

module spike_filter (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic raw_in,
  input wire logic [1:0] sel_in,
  output logic filtered_out
);
  logic [8:0] cnt_q;
  logic [8:0] cnt_d;
  logic out_q;
  logic out_d;
  logic [8:0] thr;

  always_comb begin
    unique case (sel_in)
      2'h0: thr = 9'(`FILT0_CYC);
      2'h1: thr = 9'(`FILT1_CYC);
      2'h2: thr = 9'(`FILT2_CYC);
      2'h3: thr = 9'(`FILT3_CYC);
    endcase
  end

  // any low sample restarts the count, so spikes shorter than thr vanish
  always_comb begin
    cnt_d = cnt_q;
    out_d = 1'b0;
    if (!raw_in) begin
      cnt_d = 9'h000;
    end else if (cnt_q < thr - 9'h001) begin
      cnt_d = cnt_q + 9'h001;
    end else begin
      out_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= 9'h000;
      out_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign filtered_out = out_q;
endmodule : spike_filter

`default_nettype wire

// ==== logic/motor_driver_fault_protection.sv ====
// temperature, short and open load protection for a two-bridge motor driver
// assumes analog comparator and detector levels arrive asynchronously on pins,
// chopper strobes and standstill come from logic on core_clk_in
`timescale 1ns/100ps
`include "fault_prot_defs.svh"
`default_nettype none

// Contract
// - prewarn flag, shutdown with three selectable levels
// - shutdown holds until prewarn clears
// - three retries, then latch bridge off
// - switch off affected bridge, flag detector
// - restart only after disable then enable
// - two-bit spike filter, 100ns to 3us
// - blank detection 750ns or 1500ns
// - lowside disable ignores supply short
// - highside disable ignores ground short
// - highside level 2..15, reset from otp
// - programmable lowside overcurrent level
// - open load when current not reached
// - no open load check at standstill
// - open load flags are status only; they also set irq status bits 5:4
module motor_driver_fault_protection (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire logic [3:0] temp_cmp_in,
  input wire logic [1:0] short_gnd_in,
  input wire logic [1:0] short_sup_in,
  input wire logic [1:0] bridge_switch_in,
  input wire logic [1:0] chop_cycle_end_in,
  input wire logic [1:0] current_reached_in,
  input wire logic standstill_in,
  input wire logic [3:0] otp_highside_level_in,
  output logic [1:0] bridge_enable_out,
  output logic [3:0] lowside_fault_level_out,
  output logic [3:0] highside_fault_level_out,
  output logic irq_out
);
  // pin synchronisers: stage 1 feeds stage 2 only
  logic [7:0] sync1_q;
  logic [7:0] sync2_q;
  logic [3:0] temp_s;
  logic [1:0] gnd_s;
  logic [1:0] sup_s;
  logic [1:0] filt_gnd;
  logic [1:0] filt_sup;

  fault_prot_pkg::ctrl_t ctrl_q;
  fault_prot_pkg::ctrl_t ctrl_d;
  fault_prot_pkg::fault_cfg_t cfg_q;
  fault_prot_pkg::fault_cfg_t cfg_d;
  logic otp_done_q;
  logic otp_done_d;
  logic prewarn_q;
  logic prewarn_d;
  logic ot_shut_q;
  logic ot_shut_d;
  logic ot_level;
  fault_prot_pkg::bridge_state_t br_st_q [2];
  fault_prot_pkg::bridge_state_t br_st_d [2];
  logic [1:0] retry_q [2];
  logic [1:0] retry_d [2];
  logic [11:0] tmr_q [2];
  logic [11:0] tmr_d [2];
  logic [7:0] blank_q [2];
  logic [7:0] blank_d [2];
  logic [1:0] gnd_flag_q;
  logic [1:0] gnd_flag_d;
  logic [1:0] sup_flag_q;
  logic [1:0] sup_flag_d;
  logic [1:0] latch_ev;
  logic [1:0] ol_q;
  logic [1:0] ol_d;
  logic [1:0] br_en_q;
  logic [1:0] br_en_d;
  logic [`IRQ_BITS-1:0] irq_st_q;
  logic [`IRQ_BITS-1:0] irq_st_d;
  logic [`IRQ_BITS-1:0] irq_mask_q;
  logic [`IRQ_BITS-1:0] irq_mask_d;
  logic [`IRQ_BITS-1:0] irq_ev;
  logic irq_q;
  logic irq_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [31:0] status_word;
  logic [7:0] blank_len;
  logic en_rise;
  logic wr_ctrl;
  logic wr_fcfg;
  logic [3:0] hs_wr;

  // two-flop synchronisers for comparator and detector pins
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
    end else begin
      sync1_q <= {short_sup_in, short_gnd_in, temp_cmp_in};
      sync2_q <= sync1_q;
    end
  end

  assign temp_s = sync2_q[3:0];
  assign gnd_s = sync2_q[5:4];
  assign sup_s = sync2_q[7:6];

  // one filter per detector line, same setting for all four
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_filt
      spike_filter u_gnd (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .raw_in(gnd_s[gi]),
        .sel_in(cfg_q.filt_sel),
        .filtered_out(filt_gnd[gi])
      );
      spike_filter u_sup (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .raw_in(sup_s[gi]),
        .sel_in(cfg_q.filt_sel),
        .filtered_out(filt_sup[gi])
      );
    end
  endgenerate

  assign wr_ctrl = reg_wr_in && (reg_addr_in == `ADDR_CTRL);
  assign wr_fcfg = reg_wr_in && (reg_addr_in == `ADDR_FCFG);
  assign hs_wr = reg_wdata_in[`FCFG_HS_HI:`FCFG_HS_LO];

  // control and configuration registers
  always_comb begin
    ctrl_d = ctrl_q;
    cfg_d = cfg_q;
    otp_done_d = 1'b1;
    if (wr_ctrl) begin
      ctrl_d.drv_en = reg_wdata_in[`CTRL_EN_BIT];
      ctrl_d.ot_sel = reg_wdata_in[`CTRL_OTSEL_HI:`CTRL_OTSEL_LO];
      ctrl_d.ls_dis = reg_wdata_in[`CTRL_LSDIS_BIT];
      ctrl_d.hs_dis = reg_wdata_in[`CTRL_HSDIS_BIT];
    end
    if (!otp_done_q) begin
      cfg_d.hs_level = (otp_highside_level_in < `HS_LEVEL_MIN) ?
                       `HS_LEVEL_MIN : otp_highside_level_in;
    end
    if (wr_fcfg) begin
      cfg_d.ls_level = reg_wdata_in[`FCFG_LS_HI:`FCFG_LS_LO];
      cfg_d.hs_level = (hs_wr < `HS_LEVEL_MIN) ? `HS_LEVEL_MIN : hs_wr;
      cfg_d.filt_sel = reg_wdata_in[`FCFG_FILT_HI:`FCFG_FILT_LO];
      cfg_d.blank_long = reg_wdata_in[`FCFG_DELAY_BIT];
    end
  end

  // otp strap is caught by the first clocked cycle after reset release
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_q <= '0;
      cfg_q <= {1'b0, `FILT_RST, `HS_LEVEL_MIN, `LS_LEVEL_RST};
      otp_done_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      cfg_q <= cfg_d;
      otp_done_q <= otp_done_d;
    end
  end

  always_comb begin
    unique case (ctrl_q.ot_sel)
      2'h0: ot_level = temp_s[1];
      2'h1: ot_level = temp_s[2];
      2'h2: ot_level = temp_s[3];
      2'h3: ot_level = temp_s[3];
    endcase
  end

  // thermal state; hysteresis down to prewarn stops heating cycles
  always_comb begin
    prewarn_d = temp_s[0];
    ot_shut_d = ot_shut_q;
    if (ot_level) begin
      ot_shut_d = 1'b1;
    end else if (!temp_s[0]) begin
      ot_shut_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      prewarn_q <= 1'b0;
      ot_shut_q <= 1'b0;
    end else begin
      prewarn_q <= prewarn_d;
      ot_shut_q <= ot_shut_d;
    end
  end

  assign en_rise = ctrl_d.drv_en && !ctrl_q.drv_en;
  assign blank_len = cfg_q.blank_long ? 8'(`BLANK1_CYC) : 8'(`BLANK0_CYC);

  // per-bridge short handling with retry and latch
  always_comb begin
    logic det_g;
    logic det_s;
    det_g = 1'b0;
    det_s = 1'b0;
    gnd_flag_d = gnd_flag_q;
    sup_flag_d = sup_flag_q;
    latch_ev = 2'b00;
    for (int i = 0; i < 2; i++) begin
      br_st_d[i] = br_st_q[i];
      retry_d[i] = retry_q[i];
      tmr_d[i] = tmr_q[i];
      blank_d[i] = blank_q[i];
      det_g = filt_gnd[i] && !ctrl_q.hs_dis;
      det_s = filt_sup[i] && !ctrl_q.ls_dis;
      if (bridge_switch_in[i]) begin
        blank_d[i] = blank_len;
      end else if (blank_q[i] != 8'h00) begin
        blank_d[i] = blank_q[i] - 8'h01;
      end
      if (!ctrl_q.drv_en) begin
        br_st_d[i] = fault_prot_pkg::BR_RUN;
        retry_d[i] = 2'h0;
        tmr_d[i] = 12'h000;
      end else begin
        unique case (br_st_q[i])
          fault_prot_pkg::BR_RUN: begin
            if (br_en_q[i] && blank_q[i] == 8'h00 && (det_g || det_s)) begin
              if (retry_q[i] == `RETRY_MAX) begin
                br_st_d[i] = fault_prot_pkg::BR_LATCH;
                latch_ev[i] = 1'b1;
                gnd_flag_d[i] = gnd_flag_q[i] | det_g;
                sup_flag_d[i] = sup_flag_q[i] | det_s;
              end else begin
                br_st_d[i] = fault_prot_pkg::BR_RETRY;
                retry_d[i] = retry_q[i] + 2'h1;
                tmr_d[i] = 12'(`RETRY_OFF_CYC);
              end
            end else if (tmr_q[i] != 12'h000) begin
              tmr_d[i] = tmr_q[i] - 12'h001;
            end else begin
              retry_d[i] = 2'h0; // clean run forgets single events
            end
          end
          fault_prot_pkg::BR_RETRY: begin
            if (tmr_q[i] != 12'h000) begin
              tmr_d[i] = tmr_q[i] - 12'h001;
            end else begin
              br_st_d[i] = fault_prot_pkg::BR_RUN;
              tmr_d[i] = 12'(`RETRY_HOLD_CYC);
              blank_d[i] = blank_len;
            end
          end
          fault_prot_pkg::BR_LATCH: begin
            br_st_d[i] = fault_prot_pkg::BR_LATCH;
          end
          default: begin
            br_st_d[i] = fault_prot_pkg::BR_LATCH; // illegal code fails safe
          end
        endcase
      end
      if (en_rise) begin
        gnd_flag_d[i] = 1'b0;
        sup_flag_d[i] = 1'b0;
      end
      br_en_d[i] = ctrl_d.drv_en && !ot_shut_d && br_st_d[i] == fault_prot_pkg::BR_RUN;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < 2; i++) begin
        br_st_q[i] <= fault_prot_pkg::BR_RUN;
        retry_q[i] <= 2'h0;
        tmr_q[i] <= 12'h000;
        blank_q[i] <= 8'h00;
      end
      gnd_flag_q <= 2'b00;
      sup_flag_q <= 2'b00;
      br_en_q <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        br_st_q[i] <= br_st_d[i];
        retry_q[i] <= retry_d[i];
        tmr_q[i] <= tmr_d[i];
        blank_q[i] <= blank_d[i];
      end
      gnd_flag_q <= gnd_flag_d;
      sup_flag_q <= sup_flag_d;
      br_en_q <= br_en_d;
    end
  end

  // open load evaluation at each chopper cycle end
  always_comb begin
    ol_d = ol_q;
    for (int i = 0; i < 2; i++) begin
      if (chop_cycle_end_in[i] && !standstill_in && br_en_q[i]) begin
        ol_d[i] = !current_reached_in[i];
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ol_q <= 2'b00;
    end else begin
      ol_q <= ol_d;
    end
  end

  // sticky interrupt status: a new event beats a same-cycle clear
  always_comb begin
    irq_ev = {ol_d & ~ol_q, latch_ev, ot_shut_d & !ot_shut_q, prewarn_d & !prewarn_q};
    irq_st_d = irq_st_q;
    irq_mask_d = irq_mask_q;
    if (reg_wr_in && reg_addr_in == `ADDR_IRQ_ST) begin
      irq_st_d = irq_st_q & ~reg_wdata_in[`IRQ_BITS-1:0];
    end
    if (reg_wr_in && reg_addr_in == `ADDR_IRQ_MASK) begin
      irq_mask_d = reg_wdata_in[`IRQ_BITS-1:0];
    end
    irq_st_d = irq_st_d | irq_ev;
    irq_d = |(irq_st_d & irq_mask_d);
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_st_q <= '0;
      irq_mask_q <= '0;
      irq_q <= 1'b0;
    end else begin
      irq_st_q <= irq_st_d;
      irq_mask_q <= irq_mask_d;
      irq_q <= irq_d;
    end
  end

  assign status_word = {21'h000000, ot_level, br_en_q, ol_q, sup_flag_q, gnd_flag_q,
                        ot_shut_q, prewarn_q};

  // read mux; unmapped offsets read zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        `ADDR_CTRL: rdata_d = {26'h0000000, ctrl_q.hs_dis, ctrl_q.ls_dis, 1'b0,
                               ctrl_q.ot_sel, ctrl_q.drv_en};
        `ADDR_FCFG: rdata_d = {13'h0000, cfg_q.blank_long, cfg_q.filt_sel, 4'h0,
                               cfg_q.hs_level, 4'h0, cfg_q.ls_level};
        `ADDR_STATUS: rdata_d = status_word;
        `ADDR_IRQ_ST: rdata_d = {26'h0000000, irq_st_q};
        `ADDR_IRQ_MASK: rdata_d = {26'h0000000, irq_mask_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign bridge_enable_out = br_en_q;
  assign lowside_fault_level_out = cfg_q.ls_level;
  assign highside_fault_level_out = cfg_q.hs_level;
  assign irq_out = irq_q;
endmodule : motor_driver_fault_protection

`default_nettype wire

// ==== tb/fault_prot_chk.sv ====
// port-level assertions for the fault protection block
// bound from the bench top; sees only the top module's ports
`timescale 1ns/100ps
`include "fault_prot_defs.svh"
`default_nettype none

module fault_prot_chk (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic [3:0] temp_cmp_in,
  input wire logic [1:0] short_gnd_in,
  input wire logic [1:0] short_sup_in,
  input wire logic [1:0] bridge_enable_out,
  input wire logic [3:0] lowside_fault_level_out,
  input wire logic [3:0] highside_fault_level_out,
  input wire logic irq_out
);
  logic [1:0][3:0] calm_q;
  logic [1:0][3:0] calm_d;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  // quiet cycles per bridge: no write, no heat, no short on its own pins
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      calm_d[i] = (calm_q[i] == 4'hf) ? calm_q[i] : calm_q[i] + 4'h1;
      if (reg_wr_in || (temp_cmp_in != 4'h0) || short_gnd_in[i] || short_sup_in[i]) begin
        calm_d[i] = 4'h0;
      end
    end
  end
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      calm_q <= '0;
    end else begin
      calm_q <= calm_d;
    end
  end

  a_hs_level_floor: assert property (highside_fault_level_out >= 4'h2)
    else $error("highside level below floor");
  a_hs_level_load: assert property ((reg_wr_in && reg_addr_in == `ADDR_FCFG) |=>
    highside_fault_level_out == (($past(reg_wdata_in[11:8]) < 4'h2) ? 4'h2
    : $past(reg_wdata_in[11:8]))) else $error("highside level not loaded");
  a_ls_level_load: assert property ((reg_wr_in && reg_addr_in == `ADDR_FCFG) |=>
    lowside_fault_level_out == $past(reg_wdata_in[3:0])) else $error("lowside level not loaded");
  a_ls_level_hold: assert property ($changed(lowside_fault_level_out) |->
    $past(reg_wr_in) && $past(reg_addr_in) == `ADDR_FCFG) else $error("lowside level moved");
  a_hot_bridges_off: assert property (temp_cmp_in[3] [*6] |-> bridge_enable_out == 2'b00)
    else $error("bridges on above top threshold");
  a_warm_stays_off: assert property (temp_cmp_in[3] [*6] ##1 temp_cmp_in[0] [*5] |->
    bridge_enable_out == 2'b00) else $error("bridges back on above prewarn");
  // a quiet bridge never drops, whatever open load or the other bridge does
  a_calm_keeps_a: assert property (calm_q[0] >= 4'h8 |-> !$fell(bridge_enable_out[0]))
    else $error("bridge a dropped without cause");
  a_calm_keeps_b: assert property (calm_q[1] >= 4'h8 |-> !$fell(bridge_enable_out[1]))
    else $error("bridge b dropped without cause");

  c_bridge_a_drop: cover property ($fell(bridge_enable_out[0]));
  c_bridge_b_drop: cover property ($fell(bridge_enable_out[1]));
  c_irq_raise: cover property ($rose(irq_out));
  c_thermal_hold: cover property (temp_cmp_in[3] [*6] ##1 temp_cmp_in[0] [*5]);
endmodule : fault_prot_chk

`default_nettype wire

// ==== tb/power_stage_model.sv ====
// behavioural power stage and coils facing the protection block
// fault and open coil controls come from the bench
`timescale 1ns/100ps
`default_nettype none

module power_stage_model (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [1:0] bridge_enable_in,
  input wire logic [1:0] gnd_fault_in,
  input wire logic [1:0] sup_fault_in,
  input wire logic [1:0] open_coil_in,
  output logic [1:0] short_gnd_out,
  output logic [1:0] short_sup_out,
  output logic [1:0] bridge_switch_out,
  output logic [1:0] chop_cycle_end_out,
  output logic [1:0] current_reached_out
);
  logic [8:0] phase_q;
  // short current only flows through a conducting bridge
  assign short_gnd_out = gnd_fault_in & bridge_enable_in;
  assign short_sup_out = sup_fault_in & bridge_enable_in;
  // an open coil never reaches target current
  assign current_reached_out = ~open_coil_in & bridge_enable_in;
  // sparse switching so blanking leaves room for detection
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      phase_q <= 9'h000;
      bridge_switch_out <= 2'b00;
      chop_cycle_end_out <= 2'b00;
    end else begin
      phase_q <= phase_q + 9'h001;
      bridge_switch_out <= {2{phase_q == 9'h1ff}};
      chop_cycle_end_out <= {2{phase_q[4:0] == 5'h1f}};
    end
  end
endmodule : power_stage_model

`default_nettype wire

// ==== tb/motor_driver_fault_protection_tb.sv ====
// self-checking bench for the fault protection block
// drives registers, temperature and shorts; power stage is modelled
`timescale 1ns/100ps
`include "fault_prot_defs.svh"
`default_nettype none

module motor_driver_fault_protection_tb;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [31:0] reg_rdata_out;
  logic [3:0] temp_cmp_in = 4'h0;
  logic [1:0] short_gnd_in, short_sup_in, bridge_switch_in, chop_cycle_end_in;
  logic [1:0] current_reached_in, bridge_enable_out;
  logic standstill_in = 1'b1;
  logic [3:0] otp_highside_level_in = 4'h1;
  logic [3:0] lowside_fault_level_out, highside_fault_level_out;
  logic irq_out;
  logic [1:0] gnd_fault = 2'b00;
  logic [1:0] sup_fault = 2'b00;
  logic [1:0] open_coil = 2'b00;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int falls = 0;
  int on_len = 0;
  int min_on = 9999;
  localparam logic [31:0] case_ctrl [4] = '{32'h01, 32'h01, 32'h21, 32'h11};
  localparam logic [1:0] case_gnd [4] = '{2'b01, 2'b00, 2'b10, 2'b00};
  localparam logic [1:0] case_sup [4] = '{2'b00, 2'b10, 2'b00, 2'b01};
  localparam logic [1:0] case_be [4] = '{2'b10, 2'b01, 2'b11, 2'b11};
  localparam logic [31:0] case_st [4] = '{32'h204, 32'h120, 32'h300, 32'h300};

  always #5 core_clk_in = ~core_clk_in;

  motor_driver_fault_protection i_motor_driver_fault_protection (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .temp_cmp_in(temp_cmp_in), .short_gnd_in(short_gnd_in),
    .short_sup_in(short_sup_in), .bridge_switch_in(bridge_switch_in),
    .chop_cycle_end_in(chop_cycle_end_in), .current_reached_in(current_reached_in),
    .standstill_in(standstill_in), .otp_highside_level_in(otp_highside_level_in),
    .bridge_enable_out(bridge_enable_out), .lowside_fault_level_out(lowside_fault_level_out),
    .highside_fault_level_out(highside_fault_level_out), .irq_out(irq_out));

  power_stage_model i_power_stage_model (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .bridge_enable_in(bridge_enable_out),
    .gnd_fault_in(gnd_fault), .sup_fault_in(sup_fault), .open_coil_in(open_coil),
    .short_gnd_out(short_gnd_in), .short_sup_out(short_sup_in),
    .bridge_switch_out(bridge_switch_in), .chop_cycle_end_out(chop_cycle_end_in),
    .current_reached_out(current_reached_in));

  // every bridge drop counts, retries included
  always @(negedge bridge_enable_out[0]) falls++;
  always @(negedge bridge_enable_out[1]) falls++;

  // shortest spell with both bridges on after a retry; blanking sets its length
  always @(negedge core_clk_in) begin
    if (&bridge_enable_out) begin
      on_len++;
    end else begin
      if (on_len > 0 && falls > 1 && on_len < min_on) begin
        min_on = on_len;
      end
      on_len = 0;
    end
  end

  // hang guard: whole sequence needs well under 30000 cycles
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles > 40000) begin
      num_errors++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    chk(reg_rdata_out, exp);
  endtask : rd

  initial begin
    repeat (8) @(posedge core_clk_in);
    rst_in <= 1'b0;
    tick(3);
    chk(32'(lowside_fault_level_out), 32'h6);
    chk(32'(highside_fault_level_out), 32'h2);
    rd(`ADDR_FCFG, 32'h00010206);
    wr(`ADDR_FCFG, 32'h00010103);
    rd(`ADDR_FCFG, 32'h00010203);
    wr(`ADDR_FCFG, 32'h00010f0f);
    rd(`ADDR_FCFG, 32'h00010f0f);
    rd(8'h14, 32'h0);
    wr(`ADDR_IRQ_MASK, 32'h0c);
    // each shutdown select: level below passes, selected level trips
    for (int s = 0; s < 3; s++) begin
      wr(`ADDR_CTRL, 32'(s * 2 + 1));
      temp_cmp_in <= (4'h2 << s) - 4'h1;
      tick(10);
      chk(32'(bridge_enable_out), 32'h3);
      temp_cmp_in <= (4'h4 << s) - 4'h1;
      tick(10);
      rd(`ADDR_STATUS, 32'h403);
      temp_cmp_in <= 4'h1;
      tick(10);
      rd(`ADDR_STATUS, 32'h003);
      temp_cmp_in <= 4'h0;
      tick(10);
      chk(32'(bridge_enable_out), 32'h3);
    end
    // glitch shorter than the longest filter must pass unseen
    wr(`ADDR_FCFG, 32'h00030806);
    tick(5);
    falls = 0;
    gnd_fault <= 2'b01;
    tick(250);
    gnd_fault <= 2'b00;
    tick(20);
    chk(32'(falls), 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(`ADDR_FCFG, 32'h00000806 | (32'(i == 1) << `FCFG_DELAY_BIT));
      wr(`ADDR_CTRL, 32'h0);
      wr(`ADDR_CTRL, case_ctrl[i]);
      tick(5);
      falls = 0;
      min_on = 9999;
      gnd_fault <= case_gnd[i];
      sup_fault <= case_sup[i];
      tick(3000);
      chk(32'(bridge_enable_out), 32'(case_be[i]));
      chk(32'(falls), (case_be[i] == 2'b11) ? 32'h0 : 32'h4);
      chk(32'(min_on > 100), 32'(i != 0));
      rd(`ADDR_STATUS, case_st[i]);
      chk(32'(irq_out), 32'(case_be[i] != 2'b11));
      gnd_fault <= 2'b00;
      sup_fault <= 2'b00;
      tick(50);
      chk(32'(bridge_enable_out), 32'(case_be[i]));
      wr(`ADDR_IRQ_ST, 32'h0c);
      tick(2);
      chk(32'(irq_out), 32'h0);
    end
    // open coil on bridge a
    open_coil <= 2'b01;
    tick(200);
    rd(`ADDR_STATUS, 32'h300);
    standstill_in <= 1'b0;
    tick(200);
    rd(`ADDR_STATUS, 32'h340);
    chk(32'(bridge_enable_out), 32'h3);
    open_coil <= 2'b00;
    tick(200);
    rd(`ADDR_STATUS, 32'h300);
    conclude();
  end
endmodule : motor_driver_fault_protection_tb

bind motor_driver_fault_protection fault_prot_chk i_fault_prot_chk (
  .core_clk_in(core_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .temp_cmp_in(temp_cmp_in),
  .short_gnd_in(short_gnd_in), .short_sup_in(short_sup_in),
  .bridge_enable_out(bridge_enable_out), .lowside_fault_level_out(lowside_fault_level_out),
  .highside_fault_level_out(highside_fault_level_out), .irq_out(irq_out));

`default_nettype wire
